// [logic/par_chan_irq.v]
// Purpose: interrupt status, enable and configuration of the parallel channel
// Assumes: channel events arrive as one-cycle pulses from logic on aclk
// Notes: host pins and manual data pins pass two flip-flops before use
`timescale 1ns/1ns
`include "par_chan_irq_defines.vh"
`default_nettype none

module par_chan_irq (
    // Clock, reset, enable
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // AXI4-Lite write address
    input wire [9:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [9:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Channel state machine events
    input wire [7:0] negotiation_status,
    input wire remote_addr_strobe,
    input wire [7:0] remote_addr_data,
    input wire direction_reversed,
    input wire bidir_mode,
    input wire compat_active,
    input wire ident_request,
    input wire test_timer_overflow,
    // Host control pins, asynchronous
    input wire host_clk_pin,
    input wire host_busy_pin,
    input wire init_n_pin,
    input wire neg_req_pin,
    // Manual data pins
    input wire [7:0] pdata_in,
    output reg [7:0] pdata_out,
    output reg pdata_oe,
    // Configuration out to the channel
    output wire manual_select,
    output wire negotiation_enable,
    output wire transfer_enable,
    output wire ignore_select_in,
    output wire [1:0] host_timer_test_ctl,
    output wire compat_mode,
    // Interrupt
    output reg irq
);

    // Byte address of a register index
    function [9:0] reg_addr;
        input [7:0] idx;
        begin
            reg_addr = {idx, 2'b00};
        end
    endfunction

    // Register file
    reg [7:0] parallel_config;
    reg [7:0] chan_irq_enable_reg;
    reg [7:0] chan_irq_status_reg;
    reg [7:0] negotiation_status_reg;
    reg [7:0] remote_addr_reg;
    reg [7:0] manual_data_reg;
    reg [7:0] zero_detect_reg;
    reg [7:0] ones_detect_reg;
    reg [7:0] neg_status_prev;
    reg neg_primed;

    // Synchronisers
    reg [3:0] pin_meta;
    reg [3:0] pin_sync;
    reg [3:0] pin_prev;
    reg [7:0] pdata_meta;
    reg [7:0] pdata_sync;

    // AXI holding state
    reg aw_held;
    reg w_held;
    reg [9:0] aw_addr;
    reg [7:0] w_byte;
    reg w_lane0;

    wire aw_hs;
    wire w_hs;
    wire ar_hs;
    wire do_write;
    wire [9:0] wr_addr;
    wire [7:0] wr_byte;
    wire wr_lane0;
    wire wr_hit;
    wire clr_status;
    wire [3:0] pin_rise;
    wire [3:0] pin_fall;
    wire sig_edge;
    wire init_edge;
    wire neg_change;
    wire [7:0] status_set;
    wire [7:0] rd_byte;
    wire rd_hit;

    // Mode decoding from the configuration register
    assign manual_select = parallel_config[`CFG_MANUAL];
    assign negotiation_enable = parallel_config[`CFG_NEG_EN];
    assign transfer_enable = parallel_config[`CFG_XFER_EN];
    assign ignore_select_in = parallel_config[`CFG_IGN_SEL];
    assign host_timer_test_ctl = parallel_config[`CFG_TMR_HI:`CFG_TMR_LO];
    // Outside manual mode, without negotiation enable the port stays in compatibility mode
    assign compat_mode = ~manual_select & (~negotiation_enable | compat_active);

    // Readies low while frozen so no beat is taken and then lost
    assign s_axi_awready = ce & ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ce & ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ce & ~s_axi_rvalid;
    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign ar_hs = s_axi_arvalid & s_axi_arready;

    // Write fires once both address and data are present
    assign do_write = ce & ~s_axi_bvalid & (aw_held | aw_hs) & (w_held | w_hs);
    assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    assign wr_byte = w_held ? w_byte : s_axi_wdata[7:0];
    assign wr_lane0 = w_held ? w_lane0 : s_axi_wstrb[0];

    // Write address decode, unmapped gets an error response
    assign wr_hit = (wr_addr == reg_addr(`IDX_CONFIG)) |
                    (wr_addr == reg_addr(`IDX_IRQ_ENABLE)) |
                    (wr_addr == reg_addr(`IDX_IRQ_STATUS)) |
                    (wr_addr == reg_addr(`IDX_NEG_STATUS)) |
                    (wr_addr == reg_addr(`IDX_REMOTE_ADDR)) |
                    (wr_addr == reg_addr(`IDX_MANUAL_DATA)) |
                    (wr_addr == reg_addr(`IDX_ZERO_DETECT)) |
                    (wr_addr == reg_addr(`IDX_ONES_DETECT));

    // Any write value clears status; a read clears it too
    assign clr_status = (do_write & wr_lane0 &
                         (wr_addr == reg_addr(`IDX_IRQ_STATUS))) |
                        (ar_hs & (s_axi_araddr == reg_addr(`IDX_IRQ_STATUS)));

    // Edges of the synchronised host pins
    assign pin_rise = pin_sync & ~pin_prev;
    assign pin_fall = ~pin_sync & pin_prev;
    // Detect registers only act in manual mode
    assign sig_edge = manual_select &
                      (|((pin_rise & ones_detect_reg[3:0]) |
                         (pin_fall & zero_detect_reg[3:0])));
    // Leading edge of init is its falling edge
    assign init_edge = pin_fall[`PIN_INIT_N] & compat_mode;
    // No change is claimed until a previous value has been seen after reset
    assign neg_change = neg_primed & (negotiation_status != neg_status_prev);

    // Event vector, same layout as the enable register
    assign status_set[7] = 1'b0;
    assign status_set[`BIT_TEST_TIMER] = test_timer_overflow;
    assign status_set[`BIT_NEG_CHANGED] = neg_change;
    assign status_set[`BIT_SIG_EDGE] = sig_edge;
    assign status_set[`BIT_ADDR_WRITTEN] = remote_addr_strobe;
    assign status_set[`BIT_DIR_CHANGED] = direction_reversed & bidir_mode;
    assign status_set[`BIT_IDENT_REQ] = ident_request;
    assign status_set[`BIT_INIT_PULSE] = init_edge;

    // Pin synchronisers; first stage feeds only the second
    always @(posedge aclk) begin
        if (!aresetn) begin
            // Idle levels, so init_n high gives no false edge after reset
            pin_meta <= `RST_PINS;
            pin_sync <= `RST_PINS;
            pin_prev <= `RST_PINS;
            pdata_meta <= 8'h00;
            pdata_sync <= 8'h00;
        end else if (ce) begin
            pin_meta <= {neg_req_pin, init_n_pin, host_busy_pin, host_clk_pin};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
            pdata_meta <= pdata_in;
            pdata_sync <= pdata_meta;
        end
    end

    // Status register; a set in the clearing cycle survives
    always @(posedge aclk) begin
        if (!aresetn) begin
            chan_irq_status_reg <= `RST_IRQ_STATUS;
        end else if (ce) begin
            if (clr_status) begin
                chan_irq_status_reg <= status_set & `STATUS_USED;
            end else begin
                chan_irq_status_reg <= (chan_irq_status_reg | status_set) & `STATUS_USED;
            end
        end
    end

    // Interrupt level, one bit of status per enable bit
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            if (clr_status) begin
                irq <= |(status_set & chan_irq_enable_reg & `STATUS_USED);
            end else begin
                irq <= |((chan_irq_status_reg | status_set) & chan_irq_enable_reg &
                         `STATUS_USED);
            end
        end
    end

    // Negotiation status capture; write of any value clears it
    always @(posedge aclk) begin
        if (!aresetn) begin
            negotiation_status_reg <= 8'h00;
            neg_status_prev <= 8'h00;
            neg_primed <= 1'b0;
        end else if (ce) begin
            neg_status_prev <= negotiation_status;
            neg_primed <= 1'b1;
            if (neg_change) begin
                negotiation_status_reg <= negotiation_status;
            end else if (do_write & wr_lane0 &
                         (wr_addr == reg_addr(`IDX_NEG_STATUS))) begin
                negotiation_status_reg <= 8'h00;
            end
        end
    end

    // Remote address capture
    always @(posedge aclk) begin
        if (!aresetn) begin
            remote_addr_reg <= 8'h00;
        end else if (ce && remote_addr_strobe) begin
            remote_addr_reg <= remote_addr_data;
        end
    end

    // Software-written registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            parallel_config <= `RST_CONFIG;
            chan_irq_enable_reg <= `RST_IRQ_ENABLE;
            manual_data_reg <= 8'h00;
            zero_detect_reg <= `RST_DETECT;
            ones_detect_reg <= `RST_DETECT;
        end else if (do_write && wr_lane0) begin
            if (wr_addr == reg_addr(`IDX_CONFIG)) begin
                parallel_config <= wr_byte;
            end
            if (wr_addr == reg_addr(`IDX_IRQ_ENABLE)) begin
                chan_irq_enable_reg <= wr_byte & `STATUS_USED;
            end
            if (wr_addr == reg_addr(`IDX_MANUAL_DATA)) begin
                manual_data_reg <= wr_byte;
            end
            if (wr_addr == reg_addr(`IDX_ZERO_DETECT)) begin
                zero_detect_reg <= wr_byte & `DETECT_USED;
            end
            if (wr_addr == reg_addr(`IDX_ONES_DETECT)) begin
                ones_detect_reg <= wr_byte & `DETECT_USED;
            end
        end
    end

    // Manual data pins; drive only in manual, output direction and enable
    always @(posedge aclk) begin
        if (!aresetn) begin
            pdata_out <= 8'h00;
            pdata_oe <= 1'b0;
        end else if (ce) begin
            pdata_out <= manual_data_reg;
            pdata_oe <= manual_select & parallel_config[`CFG_MAN_DIR] &
                        parallel_config[`CFG_MAN_OE];
        end
    end

    // Write channel holding and response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 10'h000;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else begin
                if (aw_hs) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (w_hs) begin
                    w_held <= 1'b1;
                    w_byte <= s_axi_wdata[7:0];
                    w_lane0 <= s_axi_wstrb[0];
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // Read multiplexer, narrow registers in the low byte
    assign rd_hit = (s_axi_araddr == reg_addr(`IDX_CONFIG)) |
                    (s_axi_araddr == reg_addr(`IDX_IRQ_ENABLE)) |
                    (s_axi_araddr == reg_addr(`IDX_IRQ_STATUS)) |
                    (s_axi_araddr == reg_addr(`IDX_NEG_STATUS)) |
                    (s_axi_araddr == reg_addr(`IDX_REMOTE_ADDR)) |
                    (s_axi_araddr == reg_addr(`IDX_MANUAL_DATA)) |
                    (s_axi_araddr == reg_addr(`IDX_ZERO_DETECT)) |
                    (s_axi_araddr == reg_addr(`IDX_ONES_DETECT));
    assign rd_byte =
        (s_axi_araddr == reg_addr(`IDX_CONFIG)) ? parallel_config :
        (s_axi_araddr == reg_addr(`IDX_IRQ_ENABLE)) ? chan_irq_enable_reg :
        (s_axi_araddr == reg_addr(`IDX_IRQ_STATUS)) ? chan_irq_status_reg :
        (s_axi_araddr == reg_addr(`IDX_NEG_STATUS)) ? negotiation_status_reg :
        (s_axi_araddr == reg_addr(`IDX_REMOTE_ADDR)) ? remote_addr_reg :
        // Reverse direction reads back the written value, else the pins
        (s_axi_araddr == reg_addr(`IDX_MANUAL_DATA)) ?
            (parallel_config[`CFG_MAN_DIR] ? manual_data_reg : pdata_sync) :
        (s_axi_araddr == reg_addr(`IDX_ZERO_DETECT)) ? zero_detect_reg :
        (s_axi_araddr == reg_addr(`IDX_ONES_DETECT)) ? ones_detect_reg : 8'h00;

    // Read response, one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (ce) begin
            if (ar_hs) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // par_chan_irq

`default_nettype wire

// [logic/par_chan_irq_defines.vh]
// Purpose: constants for the parallel channel interrupt and configuration block
// Assumes: register indices are scaled by four to reach AXI4-Lite byte addresses
// Notes: definitions only
`ifndef PAR_CHAN_IRQ_DEFINES_VH
`define PAR_CHAN_IRQ_DEFINES_VH

// Register indices, byte address is four times the index
`define IDX_CONFIG 8'h20
`define IDX_IRQ_ENABLE 8'h22
`define IDX_IRQ_STATUS 8'h23
`define IDX_NEG_STATUS 8'h24
`define IDX_REMOTE_ADDR 8'h25
`define IDX_MANUAL_DATA 8'h26
`define IDX_ZERO_DETECT 8'h2c
`define IDX_ONES_DETECT 8'h2d
`define IDX_IRQ_MASK 8'h2e

// Reset values
`define RST_CONFIG 8'h00
`define RST_IRQ_ENABLE 8'h00
`define RST_IRQ_STATUS 8'h00
`define RST_DETECT 8'h00
// Host pins at their idle levels: init_n high, the rest low
`define RST_PINS 4'h4

// Status and enable bit positions, one layout for both
`define BIT_TEST_TIMER 6
`define BIT_NEG_CHANGED 5
`define BIT_SIG_EDGE 4
`define BIT_ADDR_WRITTEN 3
`define BIT_DIR_CHANGED 2
`define BIT_IDENT_REQ 1
`define BIT_INIT_PULSE 0
`define STATUS_USED 8'h7f

// Configuration bit positions
`define CFG_MANUAL 7
`define CFG_NEG_EN 6
`define CFG_XFER_EN 5
`define CFG_IGN_SEL 4
`define CFG_TMR_HI 3
`define CFG_TMR_LO 2
`define CFG_MAN_DIR 1
`define CFG_MAN_OE 0

// Host pin positions in the detect registers
`define PIN_HOST_CLK 0
`define PIN_HOST_BUSY 1
`define PIN_INIT_N 2
`define PIN_NEG_REQ 3
`define DETECT_USED 8'h0f

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [bench/par_chan_irq_properties.sv]
// Purpose: port-level properties of the channel interrupt block
// Assumes: bench offers write address and data together
// Notes: enable shadow mirrors writes taken on one edge
`timescale 1ns/1ns
`default_nettype none

module par_chan_irq_properties (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // Channel side
    input wire logic ident_request,
    input wire logic init_n_pin,
    input wire logic compat_active,
    input wire logic pdata_oe,
    input wire logic manual_select,
    input wire logic negotiation_enable,
    input wire logic compat_mode,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [9:0] ar_q;
    logic [7:0] en_q;

    // Shadow of read address and enable; split writes are not tracked
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready)
            ar_q <= s_axi_araddr;
        if (!aresetn)
            en_q <= 8'h00;
        else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                 && s_axi_awaddr == 10'h088 && s_axi_wstrb[0])
            en_q <= s_axi_wdata[7:0];
    end

    property p_oe_manual;
        pdata_oe |-> $past(manual_select);
    endproperty
    a_oe_manual: assert property (p_oe_manual) else $error("drive without manual");
    property p_manual_mode;
        manual_select |-> !compat_mode;
    endproperty
    a_manual_mode: assert property (p_manual_mode) else $error("manual yet compat");
    property p_compat_mode;
        !manual_select |-> compat_mode == (!negotiation_enable || compat_active);
    endproperty
    a_compat_mode: assert property (p_compat_mode) else $error("compat mode wrong");
    property p_bit7_zero;
        s_axi_rvalid && ar_q == 10'h08c |-> !s_axi_rdata[7];
    endproperty
    a_bit7_zero: assert property (p_bit7_zero) else $error("status bit 7 set");
    property p_ident_irq;
        ident_request && en_q[1] |-> ##[1:3] irq;
    endproperty
    a_ident_irq: assert property (p_ident_irq) else $error("no irq on ident");
    property p_init_irq;
        $fell(init_n_pin) && compat_mode && en_q[0] |-> ##[3:6] irq;
    endproperty
    a_init_irq: assert property (p_init_irq) else $error("no irq on init");
    property p_irq_gated;
        en_q == 8'h00 && $past(en_q) == 8'h00 |-> !irq;
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("irq while disabled");
    property p_b_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("late write response");
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("late read data");
endmodule // par_chan_irq_properties

`default_nettype wire

// [bench/host_port_model.sv]
// Purpose: far side, host port controller and channel events
// Assumes: the bench commands one event at a time
// Notes: address lines show inverted data once the strobe is gone
`timescale 1ns/1ns
`default_nettype none

module host_port_model (
    // Clock
    input wire logic aclk,
    // Channel events
    output logic [7:0] negotiation_status,
    output logic remote_addr_strobe,
    output logic [7:0] remote_addr_data,
    output logic direction_reversed,
    output logic ident_request,
    output logic test_timer_overflow,
    // Host pins: clock, busy, init_n, negotiation request
    output logic [3:0] pins
);
    // Idle levels, init_n inactive high
    initial begin
        negotiation_status = 8'h00;
        remote_addr_strobe = 1'b0;
        remote_addr_data = 8'h5a;
        direction_reversed = 1'b0;
        ident_request = 1'b0;
        test_timer_overflow = 1'b0;
        pins = 4'b0100;
    end

    // One event; pulses last one cycle so no stale data lingers
    task automatic fire(input int k, input logic [7:0] v);
        @(posedge aclk);
        case (k)
            0: pins[2] <= 1'b0;
            1: ident_request <= 1'b1;
            2: direction_reversed <= 1'b1;
            3: remote_addr_strobe <= 1'b1;
            4: pins <= v[3:0];
            5: negotiation_status <= v;
            default: test_timer_overflow <= 1'b1;
        endcase
        remote_addr_data <= v;
        @(posedge aclk);
        if (k == 0)
            pins[2] <= 1'b1;
        ident_request <= 1'b0;
        direction_reversed <= 1'b0;
        remote_addr_strobe <= 1'b0;
        test_timer_overflow <= 1'b0;
        remote_addr_data <= ~v;
    endtask
endmodule // host_port_model

`default_nettype wire

// [bench/par_chan_irq_bench.sv]
// Purpose: self-checking bench of the channel interrupt block
// Assumes: readies are combinational, so they are sampled mid-cycle
// Notes: a status read clears the status register
`timescale 1ns/1ns
`include "par_chan_irq_defines.vh"
`default_nettype none

module par_chan_irq_bench;
    localparam logic [9:0] A_CFG = {`IDX_CONFIG, 2'b00};
    localparam logic [9:0] A_EN = {`IDX_IRQ_ENABLE, 2'b00};
    localparam logic [9:0] A_ST = {`IDX_IRQ_STATUS, 2'b00};
    localparam logic [9:0] A_NEG = {`IDX_NEG_STATUS, 2'b00};
    localparam logic [9:0] A_ADR = {`IDX_REMOTE_ADDR, 2'b00};
    localparam logic [9:0] A_MAN = {`IDX_MANUAL_DATA, 2'b00};
    localparam logic [9:0] A_ZER = {`IDX_ZERO_DETECT, 2'b00};
    localparam logic [9:0] A_ONE = {`IDX_ONES_DETECT, 2'b00};
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, bidir = 1'b0, cact = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [9:0] awaddr = 10'h000, araddr = 10'h000;
    logic [31:0] wdata = 32'h0, got;
    logic [3:0] wstrb = 4'h1;
    logic [7:0] pin_data = 8'h00, r, q;
    logic [1:0] resp;
    wire awready, wready, bvalid, arready, rvalid, irq, oe, man, neg, xfr, compat;
    wire strobe, dirrev, ident, tovf;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] pout, nstat, adata;
    wire [3:0] pins;
    int failures = 0, comparisons = 0, cyc = 0;

    par_chan_irq u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .negotiation_status(nstat),
        .remote_addr_strobe(strobe), .remote_addr_data(adata),
        .direction_reversed(dirrev), .bidir_mode(bidir), .compat_active(cact),
        .ident_request(ident), .test_timer_overflow(tovf), .host_clk_pin(pins[0]),
        .host_busy_pin(pins[1]), .init_n_pin(pins[2]), .neg_req_pin(pins[3]),
        .pdata_in(pin_data), .pdata_out(pout), .pdata_oe(oe), .manual_select(man),
        .negotiation_enable(neg), .transfer_enable(xfr), .ignore_select_in(),
        .host_timer_test_ctl(), .compat_mode(compat), .irq(irq));

    host_port_model u_host (.aclk(aclk), .negotiation_status(nstat),
        .remote_addr_strobe(strobe), .remote_addr_data(adata),
        .direction_reversed(dirrev), .ident_request(ident),
        .test_timer_overflow(tovf), .pins(pins));

    always #2 aclk = ~aclk;

    // Hang guard, far above the expected run length
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One bus transfer; readies sampled at the falling edge before the taking edge
    task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
        logic ah, wh, dn;
        int n;
        dn = 1'b0;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= {3{w}};
        {arvalid, rready} <= {2{!w}};
        while (!dn && n < 50) begin
            @(negedge aclk);
            ah = (awvalid && awready) || (arvalid && arready);
            wh = wvalid && wready;
            dn = w ? bvalid : rvalid;
            resp = w ? bresp : rresp;
            got = rdata;
            n++;
            @(posedge aclk);
            if (ah)
                {awvalid, arvalid} <= 2'b00;
            if (wh)
                wvalid <= 1'b0;
        end
        {bready, rready} <= 2'b00;
        if (!dn)
            failures++;
        @(negedge aclk);
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        xfer(1'b0, a, 8'h00);
        chk(got, e);
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
        chk(resp, `RESP_OKAY);
    endtask

    // Fire an event, then check request line and status
    task automatic ev(input int k, input logic [7:0] v, input logic [7:0] e);
        u_host.fire(k, v);
        repeat (5) @(negedge aclk);
        chk(irq, |e);
        rd(A_ST, e);
    endtask

    initial begin
        r = $urandom(32'h1162);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_CFG, 32'h0);
        rd(A_EN, 32'h0);
        rd(A_ST, 32'h0);
        rd(10'h3fc, 32'h0);
        chk(resp, `RESP_SLVERR);
        $display("test reset finished");
        // Every combination of manual, negotiation and transfer enable with random compatibility state
        for (int i = 0; i < 8; i++) begin
            r = {i[2:0], 5'h00};
            @(posedge aclk);
            cact <= 1'($urandom);
            wr(A_CFG, r);
            rd(A_CFG, r);
            chk(man, r[7]);
            chk({neg, xfr}, r[6:5]);
            chk(compat, !r[7] && (!r[6] || cact));
        end
        $display("test modes finished");
        r = 8'($urandom);
        @(posedge aclk);
        pin_data <= ~r;
        wr(A_CFG, 8'h83);
        wr(A_MAN, r);
        chk({oe, pout}, {1'b1, r});
        wr(A_CFG, 8'h82);
        chk(oe, 1'b0);
        wr(A_CFG, 8'h81);
        rd(A_MAN, {24'h000000, ~r});
        $display("test manual finished");
        wr(A_EN, 8'h7f);
        wr(A_CFG, 8'h00);
        ev(2, 8'h00, 8'h00);
        @(posedge aclk);
        bidir <= 1'b1;
        ev(2, 8'h00, 8'h04);
        ev(1, 8'h00, 8'h02);
        ev(6, 8'h00, 8'h40);
        r = 8'($urandom);
        q = r | 8'h01;
        ev(3, r, 8'h08);
        rd(A_ADR, r);
        ev(5, q, 8'h20);
        rd(A_NEG, q);
        ev(0, 8'h00, 8'h01);
        $display("test events finished");
        wr(A_CFG, 8'h80);
        wr(A_ONE, 8'h01);
        wr(A_ZER, 8'h02);
        ev(4, 8'h05, 8'h10);
        ev(4, 8'h07, 8'h00);
        ev(4, 8'h04, 8'h10);
        $display("test detect finished");
        wr(A_EN, 8'h7d);
        u_host.fire(1, 8'h00);
        repeat (4) @(negedge aclk);
        chk(irq, 1'b0);
        wr(A_EN, 8'h7f);
        chk(irq, 1'b1);
        wr(A_ST, 8'($urandom));
        chk(irq, 1'b0);
        rd(A_ST, 32'h0);
        $display("test clear finished");
        @(posedge aclk);
        ce <= 1'b0;
        @(negedge aclk);
        chk({awready, wready, arready}, 3'b000);
        @(posedge aclk);
        ce <= 1'b1;
        $display("test enable finished");
        report_and_stop();
    end
endmodule // par_chan_irq_bench

bind par_chan_irq par_chan_irq_properties u_props (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .ident_request, .init_n_pin, .compat_active,
    .pdata_oe, .manual_select, .negotiation_enable, .compat_mode, .irq);

`default_nettype wire
